// File: core/acq_pkg.sv
// Shared constants for the acquisition controller I/O block.
// Assumes a 16-bit host I/O bus and a 16-bit chassis digital bus.
package acq_pkg;
   // ************************************************************
   // Widths and codes
   // ************************************************************
   localparam int          ACQ_DW        = 16;           // Data word width.
   localparam int          ACQ_AW        = 6;            // Device address width.
   localparam int          ACQ_MAW       = 15;           // Memory address width.
   localparam logic [15:0] ACQ_CLEAR     = 16'hF000;     // Octal 170000 clear code.
   localparam logic [5:0]  ACQ_ADDR_LO   = 6'h28;        // Octal 50.
   localparam logic [2:0]  ACQ_FN_INIT   = 3'h1;         // Initialize-chassis function.
   localparam logic [15:0] ACQ_RST_WORD  = 16'h0000;     // Input buffer after reset.
   localparam logic [14:0] ACQ_RST_ADDR  = 15'h0000;     // Address registers after reset.
   typedef enum logic [1:0] {ACQ_IDLE, ACQ_RUN, ACQ_DONE} acq_state_e;
endpackage

// File: core/acq_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the pins are quasi-static relative to i_ref_clk.
`timescale 1ns/1ps
module acq_sync #(
   parameter int W = 1
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   // First stage is read only by the second stage.
   logic [W-1:0] meta_r;
   // Both stages reset to zero.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= '0;
         o_q    <= '0;
      end else begin
         meta_r <= i_d;
         o_q    <= meta_r;
      end
   end
endmodule

// File: core/acq_io.sv
// Acquisition controller I/O: host I/O decode, block transfer into memory,
// chassis clear code, loopback input register and completion reporting.
// Assumes host bus signals are synchronous to i_ref_clk; switches and
// chassis data are pins and are synchronised.
`timescale 1ns/1ps
// Behaviour
// RULE1: Block transfer writes buffer word unchanged to memory.
// RULE2: Completion raises pollable done and interrupt. Code raises the interrupt only with i_pim_fitted set.
// RULE3: Fitted interrupt module always gets completion interrupt.
// RULE4: Clear command drives octal 170000 onto chassis.
// RULE5: Chassis resets on receiving 170000.
// RULE6: Clear only on addressed control instruction, function one.
// RULE7: Input register reads back clear code afterwards.
// RULE8: Switches select device address octal 50 to 57.
// RULE9: Output word loops back unchanged on input.
// RULE10: Respond only when instruction address matches switches.
module acq_io
   import acq_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_n,
   input  wire logic [2:0]        i_addr_sw,      // Low octal digit of address.
   input  wire logic [ACQ_AW-1:0] i_io_addr,      // Instruction device address.
   input  wire logic              i_io_out,       // Output-data instruction strobe.
   input  wire logic              i_io_in,        // Input-data instruction strobe.
   input  wire logic              i_io_ctl,       // External-control instruction strobe.
   input  wire logic [2:0]        i_io_func,      // Control function code.
   input  wire logic [ACQ_DW-1:0] i_io_wdata,     // Host output word.
   input  wire logic              i_loop_en,      // Test connector loops data back.
   input  wire logic [ACQ_DW-1:0] i_chas_data,    // Chassis data input pins.
   input  wire logic              i_chas_strobe,  // Chassis data-ready pin.
   input  wire logic              i_pim_fitted,   // Interrupt module present.
   input  wire logic [ACQ_MAW-1:0] i_btc_start,   // Block start address.
   input  wire logic [ACQ_MAW-1:0] i_btc_end,     // Block end address.
   input  wire logic              i_btc_go,       // Activate block transfer.
   input  wire logic              i_done_ack,     // Host clears completion.
   input  wire logic              i_mem_ready,    // Memory accepts write.
   output logic [ACQ_DW-1:0]      o_io_rdata,     // Data to host.
   output logic                   o_io_sel,       // Instruction addressed to us.
   output logic [ACQ_DW-1:0]      o_chas_data,    // Data lines to chassis.
   output logic                   o_chas_wr,      // Chassis write strobe.
   output logic                   o_mem_we,       // Memory write request.
   output logic [ACQ_MAW-1:0]     o_mem_addr,     // Memory write address.
   output logic [ACQ_DW-1:0]      o_mem_wdata,    // Memory write data.
   output logic                   o_done_sense,   // Pollable completion.
   output logic                   o_done_irq      // Interrupt request pulse.
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [ACQ_DW+3:0] sync_q;  // Synchronised pins.
   acq_sync #(.W(ACQ_DW+4)) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_d       ({i_addr_sw, i_chas_strobe, i_chas_data}),
      .o_q       (sync_q)
   );
   wire  [2:0]        sw_s     = sync_q[ACQ_DW+3:ACQ_DW+1];
   wire               strobe_s = sync_q[ACQ_DW];
   wire  [ACQ_DW-1:0] chas_s   = sync_q[ACQ_DW-1:0];

   // ************************************************************
   // Decode
   // ************************************************************
   // Device address is octal 5x, low digit from switches. [RULE8]
   wire [ACQ_AW-1:0] my_addr = ACQ_ADDR_LO | {3'h0, sw_s};
   // Each strobe counts only when the instruction is addressed to us.
   wire sel      = (i_io_addr == my_addr);                   // [RULE10]
   wire do_out   = sel & i_io_out;
   wire do_in    = sel & i_io_in;
   wire do_clear = sel & i_io_ctl & (i_io_func == ACQ_FN_INIT);  // [RULE6]
   // A rising edge of the synchronised chassis strobe loads one word.
   logic strobe_d_r;
   wire chas_new = strobe_s & ~strobe_d_r;

   // ************************************************************
   // Input buffer
   // ************************************************************
   logic [ACQ_DW-1:0] inbuf_r, inbuf_nxt;
   // Clear code wins, then loopback output, then chassis word.
   assign inbuf_nxt = do_clear                ? ACQ_CLEAR :   // [RULE7]
                      (do_out & i_loop_en)    ? i_io_wdata :  // [RULE9]
                      chas_new                ? chas_s : inbuf_r;
   // Buffer and edge detector registers.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         inbuf_r    <= ACQ_RST_WORD;
         strobe_d_r <= 1'b0;
      end else begin
         inbuf_r    <= inbuf_nxt;
         strobe_d_r <= strobe_s;
      end
   end

   // ************************************************************
   // Host and chassis outputs
   // ************************************************************
   wire [ACQ_DW-1:0] chas_nxt = do_clear ? ACQ_CLEAR :   // [RULE4] [RULE5]
                                do_out   ? i_io_wdata : o_chas_data;
   // Registered outputs toward host and chassis.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_io_rdata  <= '0;
         o_io_sel    <= 1'b0;
         o_chas_data <= '0;
         o_chas_wr   <= 1'b0;
      end else begin
         o_io_rdata  <= do_in ? inbuf_r : '0;
         o_io_sel    <= sel & (i_io_out | i_io_in | i_io_ctl);
         o_chas_data <= chas_nxt;
         o_chas_wr   <= do_clear | do_out;
      end
   end

   // ************************************************************
   // Block transfer channel
   // ************************************************************
   acq_state_e st_r, st_nxt;
   logic [ACQ_MAW-1:0] addr_r, end_r;
   // A write completes when the memory takes the held request.
   wire wr_fire = o_mem_we & i_mem_ready;
   wire last    = (addr_r == end_r);
   // Next-state selection.
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ACQ_IDLE: if (i_btc_go) st_nxt = ACQ_RUN;
         ACQ_RUN:  if (wr_fire && last) st_nxt = ACQ_DONE;
         ACQ_DONE: if (i_done_ack) st_nxt = ACQ_IDLE;
         default:  st_nxt = ACQ_IDLE;   // The unused code falls back to idle.
      endcase
   end
   // Channel registers; one write per address from start to end.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r        <= ACQ_IDLE;
         addr_r      <= ACQ_RST_ADDR;
         end_r       <= ACQ_RST_ADDR;
         o_mem_we    <= 1'b0;
         o_mem_addr  <= ACQ_RST_ADDR;
         o_mem_wdata <= '0;
      end else begin
         st_r <= st_nxt;
         if (st_r == ACQ_IDLE && i_btc_go) begin
            addr_r <= i_btc_start;
            end_r  <= i_btc_end;
         end else if (wr_fire) begin
            addr_r <= addr_r + 15'h0001;
         end
         if (wr_fire) begin
            o_mem_we <= 1'b0;
         end else if (st_r == ACQ_RUN && !o_mem_we) begin
            o_mem_we    <= 1'b1;            // [RULE1]
            o_mem_addr  <= addr_r;
            o_mem_wdata <= inbuf_r;         // [RULE1]
         end
      end
   end

   // ************************************************************
   // Completion reporting
   // ************************************************************
   // The transfer ends on the accepted write at the end address.
   wire finish = (st_r == ACQ_RUN) & wr_fire & last;
   // Sense is sticky; a finish in the ack cycle wins.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_done_sense <= 1'b0;
         o_done_irq   <= 1'b0;
      end else begin
         o_done_sense <= finish | (o_done_sense & ~i_done_ack);  // [RULE2]
         o_done_irq   <= finish & i_pim_fitted;                   // [RULE3]
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   // The clear command puts the clear code on the chassis lines with a write strobe.
   clear_code_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE4]
      do_clear |=> (o_chas_data == ACQ_CLEAR) && o_chas_wr)
      else $error("clear code not driven");
   // After a clear, the next addressed input returns the clear code.
   clear_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE7]
      do_clear ##1 (do_in && !chas_new && !do_out) |=> o_io_rdata == ACQ_CLEAR)
      else $error("clear code not read back");
   // An instruction for another address leaves no trace at the ports.
   no_sel_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE10]
      !sel |=> !o_chas_wr && o_io_rdata == '0)
      else $error("responded when not addressed");
   // A looped-back output word is returned by the following input.
   loop_back_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE9]
      (do_out && i_loop_en && !do_clear) ##1 (do_in && !do_clear && !do_out && !chas_new)
      |=> o_io_rdata == $past(i_io_wdata, 2))
      else $error("loopback word changed");
   // With the interrupt module present, completion raises both indications.
   done_irq_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE3]
      finish && i_pim_fitted |=> o_done_irq && o_done_sense)
      else $error("completion interrupt missing");
   // Completion always raises the pollable indication.
   done_sense_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE2]
      finish |=> o_done_sense)
      else $error("completion sense missing");
   // The pollable indication stands until the host acknowledges it.
   sense_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE2]
      o_done_sense && !i_done_ack |=> o_done_sense)
      else $error("completion sense dropped early");
   // Without the interrupt module no interrupt pulse is raised.
   irq_gated_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE3]
      !i_pim_fitted |=> !o_done_irq)
      else $error("interrupt without interrupt module");
   // Each memory write carries the buffered word.
   mem_data_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE1]
      (st_r == ACQ_RUN && !o_mem_we) |=> o_mem_we && o_mem_wdata == $past(inbuf_r))
      else $error("memory word differs from buffer");
   // A stalled write keeps its address and word until memory takes it.
   mem_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE1]
      o_mem_we && !i_mem_ready |=> o_mem_we && $stable(o_mem_addr) && $stable(o_mem_wdata))
      else $error("memory request changed while stalled");
   // Any strobe at octal 5x with the switch digit is answered.
   addr_match_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [RULE8]
      (i_io_out || i_io_in || i_io_ctl) && i_io_addr == {ACQ_ADDR_LO[5:3], sw_s}
      |=> o_io_sel)
      else $error("switch-selected address not answered");
endmodule

// File: test/acq_chas_model.sv
// Behavioural model of the analog chassis on the far side of the digital bus.
// Assumes the bench calls send() at a falling edge of i_ref_clk.
`timescale 1ns/1ps
module acq_chas_model
   import acq_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic [ACQ_DW-1:0] i_data,       // Word from the controller.
   input  wire logic              i_wr,         // Controller write strobe.
   output logic      [ACQ_DW-1:0] o_data,       // Word to the controller.
   output logic                   o_strobe,     // Data-ready to the controller.
   output logic                   o_reset_seen  // Chassis has reset itself.
);
   // Lines start idle and the chassis has not been reset.
   initial begin
      o_data = 16'hFFFF;
      o_strobe = 1'b0;
      o_reset_seen = 1'b0;
   end
   // A clear code written to the chassis resets it.
   always @(posedge i_ref_clk) begin
      if (i_wr === 1'b1 && i_data === ACQ_CLEAR) o_reset_seen <= 1'b1;
   end
   // Present a word, flag it ready, then let the held lines drift to the inverse.
   task automatic send(input logic [ACQ_DW-1:0] w);
      o_data = w;
      repeat (2) @(negedge i_ref_clk);
      o_strobe = 1'b1;
      repeat (4) @(negedge i_ref_clk);
      o_strobe = 1'b0;
      repeat (4) @(negedge i_ref_clk);
      o_data = ~w;
   endtask
endmodule

// File: test/acq_io_tb.sv
// Self-checking bench for the acquisition controller I/O block.
// Assumes the chassis model in acq_chas_model.sv; inputs change on falling edges.
`timescale 1ns/1ps
module acq_io_tb;
   import acq_pkg::*;
   logic ref_clk, rst_n, io_out, io_in, io_ctl, loop_en, priority_interrupt_module, go, ack, rdy, sel, cwr, we;
   logic sense, irq, stb, rst_seen;
   logic [2:0] sw, func;
   logic [5:0] addr;
   logic [15:0] wd, rd, cout, cin, mwd;
   logic [14:0] bs, be, ma;
   int mismatches, num_checks;
   wire logic [5:0] me = ACQ_ADDR_LO + {3'h0, sw}; // Address the switches select.
   acq_io dut (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_addr_sw(sw), .i_io_addr(addr),
      .i_io_out(io_out), .i_io_in(io_in), .i_io_ctl(io_ctl), .i_io_func(func),
      .i_io_wdata(wd), .i_loop_en(loop_en), .i_chas_data(cin), .i_chas_strobe(stb),
      .i_pim_fitted(priority_interrupt_module), .i_btc_start(bs), .i_btc_end(be), .i_btc_go(go),
      .i_done_ack(ack), .i_mem_ready(rdy), .o_io_rdata(rd), .o_io_sel(sel),
      .o_chas_data(cout), .o_chas_wr(cwr), .o_mem_we(we), .o_mem_addr(ma),
      .o_mem_wdata(mwd), .o_done_sense(sense), .o_done_irq(irq));
   acq_chas_model chas (.i_ref_clk(ref_clk), .i_data(cout), .i_wr(cwr), .o_data(cin),
      .o_strobe(stb), .o_reset_seen(rst_seen));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Compare one value and count it.
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // Present one host instruction for one edge; its answer shows at the next fall.
   task automatic io(input logic o, i, c, input logic [2:0] f, input logic [5:0] a,
                     input logic [15:0] d);
      io_out = o;
      io_in = i;
      io_ctl = c;
      func = f;
      addr = a;
      wd = d;
      @(negedge ref_clk);
   endtask
   // Switch settings, address match and loopback of every setting.
   task automatic t_addr;
      loop_en = 1'b1;
      for (int s = 0; s < 8; s++) begin
         io(0, 0, 0, 3'h0, 6'h00, 16'h0);
         sw = s[2:0];
         repeat (3) @(negedge ref_clk);
         io(1, 0, 0, 3'h0, me, {s[2:0], 13'h0ABC});
         chk("sel", 16'h1, {15'h0, sel});
         io(0, 1, 0, 3'h0, me, 16'h0);
         chk("loop", {s[2:0], 13'h0ABC}, rd);
         io(0, 1, 1, ACQ_FN_INIT, me ^ 6'h01, 16'h0);
         chk("nsel", 16'h0, {15'h0, sel});
         chk("nrd", 16'h0, rd);
         chk("nwr", 16'h0, {15'h0, cwr});
      end
      // Shifting patterns, output and input back to back.
      for (int i = 0; i < 16; i++) begin
         io(1, 0, 0, 3'h0, me, 16'hFFFF >> i);
         io(0, 1, 0, 3'h0, me, 16'h0);
         chk("path", 16'hFFFF >> i, rd);
      end
   endtask
   // Every function code; only function one writes the clear code.
   task automatic t_clear;
      for (int f = 7; f >= 0; f--) begin
         io(0, 0, 1, f[2:0], me, 16'h0);
         chk("cwr", {15'h0, f == 1}, {15'h0, cwr});
      end
      io(0, 1, 0, 3'h0, me, 16'h0);
      chk("cdata", ACQ_CLEAR, cout);
      chk("cread", ACQ_CLEAR, rd);
      chk("creset", 16'h1, {15'h0, rst_seen});
      io(0, 0, 0, 3'h0, 6'h00, 16'h0);
   endtask
   // Chassis word into the buffer, then a block transfer with memory stalls.
   task automatic t_block(input logic p, input logic [14:0] s, e, input logic [15:0] w);
      int n, k;
      loop_en = 1'b0;
      priority_interrupt_module = p;
      chas.send(w);
      bs = s;
      be = e;
      go = 1'b1;
      @(negedge ref_clk);
      go = 1'b0;
      n = 0;
      for (k = 0; k < 80 && sense !== 1'b1; k++) begin
         if (rdy === 1'b1) begin
            rdy = 1'b0;
         end else if (we === 1'b1 && k[0]) begin
            chk("maddr", {1'b0, s + 15'(n)}, {1'b0, ma});
            chk("mdata", w, mwd);
            n++;
            rdy = 1'b1;
         end
         @(negedge ref_clk);
      end
      if (k == 80) begin
         mismatches++;
         finish_test();
      end
      chk("words", 16'(e - s + 15'h1), 16'(n));
      chk("irq", {15'h0, p}, {15'h0, irq});
      ack = 1'b1;
      @(negedge ref_clk);
      ack = 1'b0;
      @(negedge ref_clk);
      chk("sense", 16'h0, {15'h0, sense});
   endtask
   // Report the counts and the verdict, then stop.
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Reset for eight cycles, then run the scenarios.
   initial begin
      {rst_n, io_out, io_in, io_ctl, loop_en, priority_interrupt_module, go, ack, rdy} = '0;
      {sw, func, addr, wd, bs, be} = '0;
      repeat (8) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      t_addr();
      t_clear();
      t_block(1'b1, 15'h0010, 15'h0012, 16'hA5C3);
      t_block(1'b0, 15'h7FFF, 15'h7FFF, 16'h3C5A);
      finish_test();
   end
endmodule
